//--- verilog/esl_defines.svh
/*
 * timing counts and selector codes for the edid select/learn controller.
 * assumes a 25 MHz core clock; counts derive from times in milliseconds.
 */
`ifndef ESL_DEFINES_SVH
`define ESL_DEFINES_SVH
`define ESL_CLK_HZ        25000000
`define ESL_SETTLE_MS     2000
`define ESL_HPD_MS        1000
`define ESL_LEARN_MS      3000
`define ESL_HDCP_MS       5000
`define ESL_DEB_MS        20
`define ESL_SLOW_HALF_MS  500
`define ESL_FAST_HALF_MS  166
`define ESL_MS2CYC(ms)    ((ms) * (`ESL_CLK_HZ / 1000))
`define ESL_POS_DYN       4'h0
`define ESL_POS_HDCP      4'h1
`define ESL_POS_FAC_LAST  4'h5
`define ESL_POS_USR_FIRST 4'h6
`define ESL_POS_USR_LAST  4'h9
`define ESL_LEN_BASE      9'h080
`define ESL_LEN_EXT       9'h100
`endif

//--- verilog/esl_pkg.sv
/*
 * types for the edid select/learn controller.
 * assumes esl_defines.svh supplies the numbers.
 */
package esl_pkg;
  typedef enum logic [2:0] {
    ESL_SRC_DYN = 3'b001,
    ESL_SRC_FAC = 3'b010,
    ESL_SRC_USR = 3'b100
  } esl_src_t;
  typedef enum logic [3:0] {
    ESL_LED_NORM = 4'b0001,
    ESL_LED_SLOW = 4'b0010,
    ESL_LED_FAST = 4'b0100,
    ESL_LED_WAIT = 4'b1000
  } esl_led_t;
endpackage

//--- verilog/esl_ctrl.sv
/*
 * front-panel controller: per-input edid selection by rotary, learn button,
 * hdcp toggle, hot-plug pulse and edid led blink feedback.
 * assumes an edid engine outside that copies, stores and strips the data;
 * this block issues one-cycle requests to it and waits for done/ok.
 */
// Notes on behaviour
// - position zero presents live sink edid, else the stored dynamic one.
// - new selection becomes active two seconds after the selector settles.
// - each presented edid change pulses that input's hot-plug for a second.
// - only positions six to nine are writable user memories.
// - learn only into active input's user slot, never in autoselect.
// - learn starts after the button is held three seconds.
// - learn success blinks the led slowly three times over three seconds.
// - learn failure blinks the led quickly three times within one second.
// - a newly attached monitor's edid is stored as the dynamic entry.
// - digital edid to an analog port has its digital descriptor stripped.
// - each digital input has its own protection enable flag.
// - selector at one plus five second hold toggles protection enable.
// - a protection change is confirmed by three quick blinks.
// - selection comes only from the rotaries; serial switch ignored.
// - zero dynamic, one to five presets, six to nine user memories.
// - storage handles base and extended length edid structures.
`include "esl_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module esl_ctrl #(
  parameter int NIN      = 4,
  parameter logic [3:0] DIG_MASK = 4'b1001,
  parameter logic [3:0] ANA_MASK = 4'b0110,
  parameter int SETTLE_CYC = `ESL_MS2CYC(`ESL_SETTLE_MS),
  parameter int HPD_CYC    = `ESL_MS2CYC(`ESL_HPD_MS),
  parameter int LEARN_CYC  = `ESL_MS2CYC(`ESL_LEARN_MS),
  parameter int HDCP_CYC   = `ESL_MS2CYC(`ESL_HDCP_MS),
  parameter int DEB_CYC    = `ESL_MS2CYC(`ESL_DEB_MS),
  parameter int SLOW_CYC   = `ESL_MS2CYC(`ESL_SLOW_HALF_MS),
  parameter int FAST_CYC   = `ESL_MS2CYC(`ESL_FAST_HALF_MS)
) (
  // clock, reset, enable
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  wire logic            clk_en,
  // front panel
  input  wire logic [4*NIN-1:0] rotary_pos,
  input  wire logic            learn_btn,
  input  wire logic [1:0]      active_in,
  input  wire logic            autoselect,
  output logic                 edid_led,
  // sink side
  input  wire logic            sink_present,
  input  wire logic [8:0]      sink_edid_len,
  // edid engine handshake
  output logic                 eng_req,
  output logic [1:0]           eng_op,
  output logic [1:0]           eng_in,
  output logic [3:0]           eng_slot,
  output logic                 eng_ext,
  output logic                 eng_strip,
  input  wire logic            eng_done,
  input  wire logic            eng_ok,
  // per input presentation
  output logic [4*NIN-1:0]     act_pos,
  output logic [NIN-1:0]       act_live,
  output logic [NIN-1:0]       hpd_n,
  output logic [NIN-1:0]       hdcp_en
);
  localparam logic [1:0] OP_APPLY = 2'h0;
  localparam logic [1:0] OP_LEARN = 2'h1;
  localparam logic [1:0] OP_DYN   = 2'h2;
  localparam int CW = 28;

  typedef struct packed {
    logic [NIN-1:0][3:0]  pend;
    logic [NIN-1:0][3:0]  act;
    logic [NIN-1:0]       live;
    logic [NIN-1:0][CW-1:0] set_cnt;
    logic [NIN-1:0][CW-1:0] hpd_cnt;
    logic [NIN-1:0]       hpd_n;
    logic [NIN-1:0]       hdcp;
    logic                 sink_d;
    logic                 btn_s;
    logic [CW-1:0]        deb_cnt;
    logic [CW-1:0]        hold_cnt;
    logic                 held3;
    logic                 hdcp_done;
    logic                 busy;
    logic                 req;
    logic [1:0]           op;
    logic [1:0]           in;
    logic [3:0]           slot;
    logic                 ext;
    logic                 strip;
    esl_pkg::esl_led_t    led_st;
    logic [CW-1:0]        led_cnt;
    logic [2:0]           led_tog;
    logic                 led;
  } esl_st_t;

  esl_st_t st_reg, st_next;

  function automatic esl_pkg::esl_src_t pos_src(input logic [3:0] p);
    if (p == `ESL_POS_DYN) return esl_pkg::ESL_SRC_DYN;
    else if (p <= `ESL_POS_FAC_LAST) return esl_pkg::ESL_SRC_FAC;
    else return esl_pkg::ESL_SRC_USR;
  endfunction

  function automatic logic is_user(input logic [3:0] p);
    return (p >= `ESL_POS_USR_FIRST) && (p <= `ESL_POS_USR_LAST);
  endfunction

  always_comb begin
    logic [3:0] rp;
    logic [3:0] ap;
    rp = 4'h0;
    ap = 4'h0;
    st_next = st_reg;
    st_next.req = 1'b0;
    st_next.sink_d = sink_present;
    // button debounce: level must hold for DEB_CYC before it counts
    if (learn_btn != st_reg.btn_s) begin
      if (st_reg.deb_cnt >= CW'(DEB_CYC - 1)) begin
        st_next.btn_s = learn_btn;
        st_next.deb_cnt = '0;
      end else begin
        st_next.deb_cnt = st_reg.deb_cnt + 1'b1;
      end
    end else begin
      st_next.deb_cnt = '0;
    end
    ap = rotary_pos[4*active_in +: 4];
    if (st_reg.btn_s) begin
      if (st_reg.hold_cnt != '1) st_next.hold_cnt = st_reg.hold_cnt + 1'b1;
    end else begin
      st_next.hold_cnt = '0;
      st_next.held3 = 1'b0;
      st_next.hdcp_done = 1'b0;
    end
    // learn: fires once per press at three seconds, only for user slots
    if (st_reg.btn_s && !st_reg.held3 && !st_reg.busy &&
        st_reg.hold_cnt == CW'(LEARN_CYC) && ap != `ESL_POS_HDCP) begin
      st_next.held3 = 1'b1;
      if (is_user(ap) && !autoselect) begin
        st_next.busy = 1'b1;
        st_next.req = 1'b1;
        st_next.op = OP_LEARN;
        st_next.in = active_in;
        st_next.slot = ap;
        st_next.ext = (sink_edid_len == `ESL_LEN_EXT);
        st_next.strip = 1'b0;
      end else begin
        st_next.led_st = esl_pkg::ESL_LED_FAST;
        st_next.led_cnt = '0;
        st_next.led_tog = '0;
      end
    end
    // protection toggle at five seconds, position one on a digital input
    if (st_reg.btn_s && !st_reg.hdcp_done && st_reg.hold_cnt == CW'(HDCP_CYC) &&
        ap == `ESL_POS_HDCP && DIG_MASK[active_in]) begin
      st_next.hdcp_done = 1'b1;
      st_next.hdcp[active_in] = !st_reg.hdcp[active_in];
      st_next.led_st = esl_pkg::ESL_LED_FAST;
      st_next.led_cnt = '0;
      st_next.led_tog = '0;
    end
    // newly attached monitor: store as dynamic entry
    if (sink_present && !st_reg.sink_d && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.req = 1'b1;
      st_next.op = OP_DYN;
      st_next.ext = (sink_edid_len == `ESL_LEN_EXT);
      st_next.strip = 1'b0;
    end
    // per input selection, only from rotaries
    for (int i = 0; i < NIN; i++) begin
      rp = rotary_pos[4*i +: 4];
      if (rp != st_reg.pend[i]) begin
        st_next.pend[i] = rp;
        st_next.set_cnt[i] = '0;
      end else if (st_reg.set_cnt[i] < CW'(SETTLE_CYC)) begin
        st_next.set_cnt[i] = st_reg.set_cnt[i] + 1'b1;
      end else if (rp != st_reg.act[i]) begin
        st_next.act[i] = rp;
        st_next.hpd_cnt[i] = CW'(HPD_CYC);
      end
      st_next.live[i] = (st_next.act[i] == `ESL_POS_DYN) && sink_present;
      if (st_next.act[i] == `ESL_POS_DYN && st_reg.live[i] != st_next.live[i])
        st_next.hpd_cnt[i] = CW'(HPD_CYC);
      if (st_reg.hpd_cnt[i] != '0 && st_next.hpd_cnt[i] == st_reg.hpd_cnt[i])
        st_next.hpd_cnt[i] = st_reg.hpd_cnt[i] - 1'b1;
      // kept active low in the state so the pin comes straight off a flop
      st_next.hpd_n[i] = (st_next.hpd_cnt[i] == '0);
    end
    // apply request for the lowest input whose active position changed, when not busy; strip set for an analog input given a non-preset source
    if (!st_reg.busy && !st_next.busy) begin
      for (int i = 0; i < NIN; i++) begin
        if (st_next.act[i] != st_reg.act[i] && !st_next.req) begin
          st_next.busy = 1'b1;
          st_next.req = 1'b1;
          st_next.op = OP_APPLY;
          st_next.in = 2'(i);
          st_next.slot = st_next.act[i];
          st_next.strip = ANA_MASK[i] &&
                          pos_src(st_next.act[i]) != esl_pkg::ESL_SRC_FAC;
        end
      end
    end
    if (st_reg.busy && eng_done) begin
      st_next.busy = 1'b0;
      if (st_reg.op == OP_LEARN) begin
        st_next.led_st = eng_ok ? esl_pkg::ESL_LED_SLOW
                                : esl_pkg::ESL_LED_FAST;
        st_next.led_cnt = '0;
        st_next.led_tog = '0;
      end
    end
    // led: normal shows steady on, blinks give six half periods
    unique case (st_reg.led_st)
      esl_pkg::ESL_LED_NORM: st_next.led = 1'b1;
      esl_pkg::ESL_LED_WAIT: st_next.led = 1'b1;
      esl_pkg::ESL_LED_SLOW, esl_pkg::ESL_LED_FAST: begin
        if (st_reg.led_cnt >= ((st_reg.led_st == esl_pkg::ESL_LED_SLOW) ?
            CW'(SLOW_CYC - 1) : CW'(FAST_CYC - 1))) begin
          st_next.led_cnt = '0;
          st_next.led_tog = st_reg.led_tog + 3'h1;
          if (st_reg.led_tog == 3'h5) st_next.led_st = esl_pkg::ESL_LED_NORM;
        end else begin
          st_next.led_cnt = st_reg.led_cnt + 1'b1;
        end
        st_next.led = st_reg.led_tog[0];
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.led_st <= esl_pkg::ESL_LED_NORM;
      st_reg.hdcp <= DIG_MASK;
      st_reg.hpd_n <= '1;
      st_reg.led <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign edid_led  = st_reg.led;
  assign eng_req   = st_reg.req;
  assign eng_op    = st_reg.op;
  assign eng_in    = st_reg.in;
  assign eng_slot  = st_reg.slot;
  assign eng_ext   = st_reg.ext;
  assign eng_strip = st_reg.strip;
  assign act_pos   = st_reg.act;
  assign act_live  = st_reg.live;
  assign hpd_n     = st_reg.hpd_n;
  // only digital inputs ever toggle, so analog bits stay at reset zero
  assign hdcp_en   = st_reg.hdcp;
endmodule // esl_ctrl
`default_nettype wire

//--- sim/esl_ctrl_props.sv
/* assertions on the ports of esl_ctrl.
   assumes a bind from the bench top; input 1 carries the hot-plug checks. */
`timescale 1ns/10ps
`default_nettype none
module esl_ctrl_props #(
  parameter int         SETTLE_CYC = 20,
  parameter int         HPD_CYC    = 10,
  parameter logic [3:0] ANA_MASK   = 4'b0110
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // panel and sink
  input wire logic [15:0] rotary_pos,
  input wire logic        learn_btn,
  input wire logic [1:0]  active_in,
  input wire logic        autoselect,
  input wire logic        edid_led,
  input wire logic        sink_present,
  input wire logic [8:0]  sink_edid_len,
  // engine and presentation
  input wire logic        eng_req,
  input wire logic [1:0]  eng_op,
  input wire logic [1:0]  eng_in,
  input wire logic [3:0]  eng_slot,
  input wire logic        eng_ext,
  input wire logic        eng_strip,
  input wire logic [15:0] act_pos,
  input wire logic [3:0]  act_live,
  input wire logic [3:0]  hpd_n,
  input wire logic [3:0]  hdcp_en
);
  localparam int HPD_LOW = HPD_CYC - 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_settle_wait: assert property ($changed(act_pos[7:4]) |->
    $past(rotary_pos[7:4], SETTLE_CYC) == act_pos[7:4])
    else $error("selection taken before settling");
  a_hpd_width: assert property ($fell(hpd_n[1]) |->
    ##HPD_LOW !hpd_n[1] ##1 hpd_n[1])
    else $error("hot-plug pulse length wrong");
  a_live_zero: assert property (act_live[0] |-> act_pos[3:0] == 4'h0)
    else $error("live edid off position zero");
  a_learn_user: assert property (eng_req && eng_op == 2'h1 |->
    eng_slot >= 4'h6 && eng_slot <= 4'h9 && eng_in == active_in
    && !autoselect)
    else $error("learn request to a bad slot");
  a_dyn_store: assert property ($rose(sink_present) |->
    ##[1:4] eng_req && eng_op == 2'h2)
    else $error("attached sink not stored");
  a_strip_ana: assert property (eng_req && eng_strip |-> ANA_MASK[eng_in])
    else $error("strip on a digital input");
  a_hdcp_digital: assert property ((hdcp_en & ANA_MASK) == 4'h0)
    else $error("protection flag on analog input");
  a_hdcp_cause: assert property ($changed(hdcp_en[0]) |->
    $past(learn_btn) && act_pos[3:0] == 4'h1)
    else $error("protection toggled without cause");
  a_hdcp_blink: assert property ($changed(hdcp_en) |-> ##[0:2] !edid_led)
    else $error("protection change not shown");
  a_ext_len: assert property (eng_req && eng_op != 2'h0 |->
    eng_ext == (sink_edid_len == 9'h100))
    else $error("extended flag does not match length");
endmodule // esl_ctrl_props
`default_nettype wire

//--- sim/esl_eng_model.sv
/* edid engine model: answers each request after LAT cycles.
   assumes eng_fail stays steady while a request is open. */
`timescale 1ns/10ps
`default_nettype none
module esl_eng_model #(
  parameter int LAT = 5
) (
  input  wire logic core_clk,
  input  wire logic eng_req,
  input  wire logic eng_fail,
  output logic      eng_done,
  output logic      eng_ok
);
  int   cnt  = 0;
  logic junk = 1'b0;
  always @(posedge core_clk) begin
    junk <= ~junk;
    eng_done <= (cnt == 1);
    if (eng_req)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // ok means nothing outside done, so it wanders
  assign eng_ok = eng_done ? ~eng_fail : junk;
endmodule // esl_eng_model
`default_nettype wire

//--- sim/esl_ctrl_test.sv
/* self-checking bench for esl_ctrl with the engine model.
   assumes shortened counts; clk_en is dropped once to check the freeze. */
`timescale 1ns/10ps
`default_nettype none
module esl_ctrl_test;
  localparam int ST = 20, HP = 10, LN = 50, HD = 90, DB = 3, SL = 8, FS = 4;
  logic        core_clk = 0, nrst = 0, clk_en = 1, learn_btn = 0;
  logic        autoselect = 0, sink_present = 0, eng_fail = 0;
  logic        eng_req, eng_ext, eng_strip, eng_done, eng_ok, edid_led;
  logic [15:0] rotary_pos = 16'h0000, act_pos;
  logic [1:0]  active_in = 2'h0, eng_op, eng_in;
  logic [3:0]  eng_slot, act_live, hpd_n, hdcp_en;
  logic [8:0]  sink_edid_len = 9'h100;
  logic [31:0] seed = 32'h0458EF28;
  logic        last_ext = 0, last_strip = 0;
  logic [3:0]  frz;
  int          err_total = 0, checks_done = 0, cyc = 0, n_learn = 0, n_low = 0;
  esl_ctrl #(.SETTLE_CYC(ST), .HPD_CYC(HP), .LEARN_CYC(LN), .HDCP_CYC(HD),
    .DEB_CYC(DB), .SLOW_CYC(SL), .FAST_CYC(FS)) dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .rotary_pos(rotary_pos), .learn_btn(learn_btn), .active_in(active_in),
    .autoselect(autoselect), .edid_led(edid_led),
    .sink_present(sink_present), .sink_edid_len(sink_edid_len),
    .eng_req(eng_req), .eng_op(eng_op), .eng_in(eng_in),
    .eng_slot(eng_slot), .eng_ext(eng_ext), .eng_strip(eng_strip),
    .eng_done(eng_done), .eng_ok(eng_ok), .act_pos(act_pos),
    .act_live(act_live), .hpd_n(hpd_n), .hdcp_en(hdcp_en));
  esl_eng_model eng (.core_clk(core_clk), .eng_req(eng_req),
    .eng_fail(eng_fail), .eng_done(eng_done), .eng_ok(eng_ok));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (eng_req && eng_op == 2'h1) n_learn++;
    if (eng_req) begin
      last_ext = eng_ext;
      last_strip = eng_strip;
    end
    if (edid_led === 1'b0) n_low++;
    if (cyc == 3000) begin
      err_total++;
      complete_run;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int blink_low(bit slow);
    return 3 * (slow ? SL : FS);
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // a change equal to the old value would show no pulse, so avoid it
  task sel(input int i, input logic [3:0] v);
    logic [3:0] old;
    old = act_pos[4*i+:4];
    if (v == old) v = (v == 4'h9) ? 4'h0 : v + 4'h1;
    @(negedge core_clk) rotary_pos[4*i+:4] = v;
    repeat (ST - 2) @(negedge core_clk);
    chk(act_pos[4*i+:4], old);
    repeat (6) @(negedge core_clk);
    chk(act_pos[4*i+:4], v);
    chk(hpd_n[i], 1'b0);
    repeat (HP + 2) @(negedge core_clk);
    chk(hpd_n[i], 1'b1);
  endtask
  task hold(input int n, input bit slow);
    @(negedge core_clk) n_low = 0;
    learn_btn = 1;
    repeat (n) @(negedge core_clk);
    learn_btn = 0;
    repeat (80) @(negedge core_clk);
    chk(16'(n_low), 16'(blink_low(slow)));
  endtask
  task complete_run;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1;
    chk(hpd_n, 4'hF);
    chk(hdcp_en, 4'b1001);
    sink_present = 1;
    repeat (20) @(negedge core_clk);
    chk(act_live[0], 1'b1);
    for (int k = 0; k < 4; k++) sel(1 + k % 2, 4'(rnd() % 10));
    // frozen clock enable: a new position must not be taken
    frz = (act_pos[11:8] == 4'h7) ? 4'h8 : 4'h7;
    clk_en = 0;
    rotary_pos[11:8] = frz;
    repeat (ST + 8) @(negedge core_clk);
    chk(16'(act_pos[11:8] == frz), 16'h0000);
    chk(hpd_n, 4'hF);
    clk_en = 1;
    sel(2, frz);
    chk(last_strip, 1'b1);
    sel(3, 4'h7);
    chk(last_strip, 1'b0);
    active_in = 2'h3;
    hold(LN + DB + 5, 1);
    chk(16'(n_learn), 16'h0001);
    chk(last_ext, 1'b1);
    eng_fail = 1;
    sink_edid_len = 9'h080;
    hold(LN + DB + 5, 0);
    chk(last_ext, 1'b0);
    eng_fail = 0;
    autoselect = 1;
    hold(LN + DB + 5, 0);
    autoselect = 0;
    chk(16'(n_learn), 16'h0002);
    sel(3, 4'h3);
    hold(LN + DB + 5, 0);
    chk(16'(n_learn), 16'h0002);
    sel(0, 4'h1);
    chk(act_live[0], 1'b0);
    active_in = 2'h0;
    hold(HD + DB + 5, 0);
    chk(hdcp_en, 4'b1000);
    // reset in mid-run: defaults return, then positions are retaken
    nrst = 0;
    repeat (2) @(negedge core_clk);
    chk(act_pos, 16'h0000);
    chk(hdcp_en, 4'b1001);
    nrst = 1;
    repeat (ST + 4) @(negedge core_clk);
    chk(act_pos, rotary_pos);
    complete_run;
  end
endmodule // esl_ctrl_test
bind esl_ctrl esl_ctrl_props #(.SETTLE_CYC(SETTLE_CYC), .HPD_CYC(HPD_CYC),
  .ANA_MASK(ANA_MASK)) u_props (
  .core_clk(core_clk), .nrst(nrst), .rotary_pos(rotary_pos),
  .learn_btn(learn_btn), .active_in(active_in), .autoselect(autoselect),
  .edid_led(edid_led), .sink_present(sink_present),
  .sink_edid_len(sink_edid_len), .eng_req(eng_req), .eng_op(eng_op),
  .eng_in(eng_in), .eng_slot(eng_slot), .eng_ext(eng_ext),
  .eng_strip(eng_strip), .act_pos(act_pos), .act_live(act_live),
  .hpd_n(hpd_n), .hdcp_en(hdcp_en));
`default_nettype wire
